// *** hdl/edcca_unit.sv ***
// Energy detection scan and clear channel assessment engine
`timescale 1ns/1ps
module edcca_unit #(
  parameter int SYM_CYCLES = edcca_pkg::SYMBOL_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Tasks, one-cycle pulses from the same clock
  input wire logic energy_scan_begin_task,
  input wire logic energy_scan_halt_task,
  input wire logic assess_begin_task,
  input wire logic assess_halt_task,
  input wire logic receive_ready_event,
  // Configuration
  input wire logic [edcca_pkg::ITER_W-1:0] energy_scan_iterations,
  input wire edcca_pkg::assess_control_t assess_control,
  input wire logic short_clear_transmit_rampup_task,
  input wire logic short_clear_stop,
  input wire logic short_busy_disable,
  input wire logic short_ready_assess,
  // Receiver observations
  input wire edcca_pkg::rx_observe_t rx_obs,
  // Results
  output logic [edcca_pkg::LEVEL_W-1:0] energy_level_result,
  output logic scan_active,
  output logic assess_active,
  output edcca_pkg::events_t events
);
  typedef enum {st_idle, st_scan, st_assess} state_t;
  state_t state_r;
  logic [edcca_pkg::SUM_W-1:0] sum_r; // Sample accumulator, wide enough for a full window
  logic [15:0] run_len_r; // Cycles the current window has run, for checking
  logic [15:0] cnt_r; // Sample count in window
  logic [edcca_pkg::ITER_W-1:0] iter_r; // Iterations left
  logic [edcca_pkg::LEVEL_W-1:0] max_r; // Maximum over iterations
  logic [edcca_pkg::PEAK_W-1:0] peaks_r; // Correlator peaks counted
  logic carrier_r; // Carrier seen in window
  logic win_start, win_abort, win_run, win_done;
  logic [edcca_pkg::LEVEL_W-1:0] avg; // Window average
  logic carrier_now, peak_hit, early_busy, energy_busy, busy;
  logic assess_go, halt_scan, halt_assess;
  edcca_pkg::assess_mode_t mode;

  // Average as sum divided by count; empty windows read zero
  function automatic logic [7:0] mean(input logic [23:0] s, input logic [15:0] n);
    logic [23:0] q;
    q = (n == 16'h0000) ? 24'h000000 : s / {8'h00, n};
    return (q > 24'h0000ff) ? 8'hff : q[7:0];
  endfunction

  assign mode = assess_control.assess_mode_select;
  assign assess_go = (assess_begin_task || (short_ready_assess && receive_ready_event))
                     && state_r == st_idle;
  assign halt_scan = energy_scan_halt_task && state_r == st_scan;
  assign halt_assess = assess_halt_task && state_r == st_assess;
  assign avg = mean(sum_r, cnt_r);
  assign carrier_now = carrier_r || rx_obs.sfd_found || rx_obs.frame_ongoing;
  assign peak_hit = assess_control.correlator_peak_limit != 8'h00 && rx_obs.corr_valid
                    && rx_obs.corr_value > assess_control.correlator_peak_threshold
                    && peaks_r + 8'h01 >= assess_control.correlator_peak_limit;
  // Early termination only matters when the carrier alone decides busy
  assign early_busy = state_r == st_assess && win_run
                      && (rx_obs.sfd_found || peak_hit)
                      && (mode == edcca_pkg::carrier_only_mode
                          || mode == edcca_pkg::carrier_or_energy_mode);
  assign energy_busy = avg >= assess_control.assess_energy_threshold;

  // Combine energy and carrier results per mode
  always_comb
  begin
    case (mode)
      edcca_pkg::energy_only_mode: busy = energy_busy;
      edcca_pkg::carrier_only_mode: busy = carrier_now;
      edcca_pkg::carrier_and_energy_mode: busy = energy_busy && carrier_now;
      default: busy = energy_busy || carrier_now;
    endcase
  end

  // Window restarts at each iteration and each new job
  assign win_start = (state_r == st_idle && (energy_scan_begin_task || assess_go))
                     || (state_r == st_scan && win_done && iter_r > 8'h01);
  assign win_abort = halt_scan || halt_assess || early_busy;

  symbol_window #(.SYM_CYCLES(SYM_CYCLES), .SYMBOLS(edcca_pkg::WINDOW_SYMBOLS)) u_win (
    .clk(clk),
    .rst_n(rst_n),
    .start(win_start),
    .abort(win_abort),
    .running(win_run),
    .done(win_done)
  );

  // Job state; scan begin has priority over assess begin when both arrive
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= st_idle;
      iter_r <= 8'h00;
    end
    else
    begin
      case (state_r)
        st_idle:
        begin
          if (energy_scan_begin_task)
          begin
            state_r <= st_scan;
            iter_r <= (energy_scan_iterations == 8'h00) ? 8'h01 : energy_scan_iterations;
          end
          else if (assess_go)
          begin
            state_r <= st_assess;
          end
        end
        st_scan:
        begin
          if (halt_scan)
            state_r <= st_idle;
          else if (win_done)
          begin
            iter_r <= iter_r - 8'h01;
            if (iter_r <= 8'h01)
              state_r <= st_idle;
          end
        end
        default:
        begin
          if (halt_assess || early_busy || win_done)
            state_r <= st_idle;
        end
      endcase
    end
  end

  // Sample averaging and carrier observation per window
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sum_r <= '0;
      cnt_r <= 16'h0000;
      peaks_r <= 8'h00;
      carrier_r <= 1'b0;
    end
    else if (win_start)
    begin
      sum_r <= '0;
      cnt_r <= 16'h0000;
      peaks_r <= 8'h00;
      carrier_r <= 1'b0;
    end
    else if (win_run)
    begin
      if (rx_obs.sample_valid)
      begin
        sum_r <= sum_r + {16'h0000, rx_obs.rssi_sample};
        cnt_r <= cnt_r + 16'h0001;
      end
      if (rx_obs.corr_valid && rx_obs.corr_value > assess_control.correlator_peak_threshold)
        peaks_r <= peaks_r + 8'h01;
      if (rx_obs.sfd_found || rx_obs.frame_ongoing || peak_hit)
        carrier_r <= 1'b1;
    end
  end

  // Result level and running maximum across iterations
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      energy_level_result <= edcca_pkg::LEVEL_RST;
      max_r <= edcca_pkg::LEVEL_RST;
    end
    else if (state_r == st_idle && energy_scan_begin_task)
      max_r <= edcca_pkg::LEVEL_RST;
    else if (state_r == st_scan && win_done)
    begin
      max_r <= (avg > max_r) ? avg : max_r;
      if (iter_r <= 8'h01)
        energy_level_result <= (avg > max_r) ? avg : max_r;
    end
  end

  // Event pulses and shortcut tasks, registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      events <= '0;
    else
    begin
      events <= '0;
      events.energy_scan_done_event <= state_r == st_scan && win_done && iter_r <= 8'h01;
      events.energy_scan_halted_event <= halt_scan;
      events.assess_halted_event <= halt_assess;
      if (state_r == st_assess && !halt_assess && (early_busy || win_done))
      begin
        events.channel_occupied_event <= early_busy || busy;
        events.channel_clear_event <= !(early_busy || busy);
        events.transmit_rampup_task <= short_clear_transmit_rampup_task && !(early_busy || busy);
        events.stop_task <= short_clear_stop && !(early_busy || busy);
        events.disable_task <= short_busy_disable && (early_busy || busy);
      end
    end
  end

  // Activity status flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scan_active <= 1'b0;
      assess_active <= 1'b0;
    end
    else
    begin
      scan_active <= state_r == st_scan;
      assess_active <= state_r == st_assess;
    end
  end

  // Window length helper; halts and early busy cut windows short, and an early busy window is still judged busy
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_len_r <= 16'h0000;
    else if (win_start)
      run_len_r <= 16'h0000;
    else if (win_run)
      run_len_r <= run_len_r + 16'h0001;
  end

  a_done_one_shot: assert property (@(posedge clk) disable iff (!rst_n)
    events.energy_scan_done_event |=> !events.energy_scan_done_event)
    else $error("done event longer than one cycle");
  a_scan_halted: assert property (@(posedge clk) disable iff (!rst_n)
    halt_scan |=> events.energy_scan_halted_event && state_r == st_idle)
    else $error("scan halt did not end scan");
  a_assess_halted: assert property (@(posedge clk) disable iff (!rst_n)
    halt_assess |=> events.assess_halted_event && !events.channel_clear_event)
    else $error("assess halt missing halted event");
  a_verdict_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
    !(events.channel_clear_event && events.channel_occupied_event))
    else $error("clear and busy together");
  a_sfd_busy: assert property (@(posedge clk) disable iff (!rst_n)
    early_busy |=> events.channel_occupied_event)
    else $error("delimiter did not end busy");
  a_transmit_rampup_task_clear: assert property (@(posedge clk) disable iff (!rst_n)
    events.transmit_rampup_task |-> events.channel_clear_event)
    else $error("transmit ramp without clear");
  a_disable_busy: assert property (@(posedge clk) disable iff (!rst_n)
    events.disable_task |-> events.channel_occupied_event && $past(short_busy_disable))
    else $error("disable without busy");
  a_ready_start: assert property (@(posedge clk) disable iff (!rst_n)
    short_ready_assess && receive_ready_event && state_r == st_idle
    && !energy_scan_begin_task |=> state_r == st_assess)
    else $error("ready shortcut did not start");
  a_window_length: assert property (@(posedge clk) disable iff (!rst_n)
    win_done |-> run_len_r == 16'(edcca_pkg::WINDOW_SYMBOLS * SYM_CYCLES))
    else $error("window length wrong");
  a_energy_mode: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == st_assess && win_done && mode == edcca_pkg::energy_only_mode
    && !halt_assess |=> events.channel_occupied_event == $past(energy_busy))
    else $error("energy verdict wrong");

  c_scan_done: cover property (@(posedge clk) events.energy_scan_done_event);
  c_clear: cover property (@(posedge clk) events.channel_clear_event);
  c_busy: cover property (@(posedge clk) events.channel_occupied_event);
  c_halt: cover property (@(posedge clk) events.assess_halted_event);
endmodule

// *** hdl/symbol_window.sv ***
// Symbol-rate enable divider and eight-symbol window counter
`timescale 1ns/1ps
module symbol_window #(
  parameter int SYM_CYCLES = edcca_pkg::SYMBOL_CYCLES,
  parameter int SYMBOLS = edcca_pkg::WINDOW_SYMBOLS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic abort,
  // Status
  output logic running,
  output logic done
);
  logic [15:0] cyc_r; // Cycles into the current symbol
  logic [7:0] sym_r; // Whole symbols elapsed
  logic sym_tick; // One-cycle enable at symbol rate

  assign sym_tick = running && (cyc_r == 16'(SYM_CYCLES - 1));

  // Divider counts only while a window runs, so every window starts aligned
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc_r <= 16'h0000;
      sym_r <= 8'h00;
      running <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        running <= 1'b0;
      end
      else if (start)
      begin
        running <= 1'b1;
        cyc_r <= 16'h0000;
        sym_r <= 8'h00;
      end
      else if (running)
      begin
        cyc_r <= sym_tick ? 16'h0000 : cyc_r + 16'h0001;
        if (sym_tick)
        begin
          // Window ends on the last symbol boundary
          if (sym_r == 8'(SYMBOLS - 1))
          begin
            running <= 1'b0;
            done <= 1'b1;
          end
          sym_r <= sym_r + 8'h01;
        end
      end
    end
  end
endmodule

// *** include/edcca_pkg.sv ***
// Shared constants and carrier types for the energy detect and channel assessment unit
package edcca_pkg;
  // Clock rate and symbol timing
  localparam int CLK_MHZ = 125;
  localparam int SYMBOL_US = 16;
  localparam int SYMBOL_CYCLES = SYMBOL_US * CLK_MHZ;
  localparam int WINDOW_SYMBOLS = 8;
  // Field widths
  localparam int LEVEL_W = 8;
  localparam int ITER_W = 8;
  localparam int PEAK_W = 8;
  localparam int SUM_W = LEVEL_W + 16; // Holds a full 16-bit count of maximum samples
  // Reset values
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [2:0] SUM_SHIFT = 3'h3;

  // Assessment mode field encoding
  typedef enum logic [1:0]
  {
    energy_only_mode = 2'h0,
    carrier_only_mode = 2'h1,
    carrier_and_energy_mode = 2'h2,
    carrier_or_energy_mode = 2'h3
  } assess_mode_t;

  // Assessment configuration group
  typedef struct packed
  {
    assess_mode_t assess_mode_select;
    logic [7:0] assess_energy_threshold;
    logic [7:0] correlator_peak_limit;
    logic [7:0] correlator_peak_threshold;
  } assess_control_t;

  // Receiver observations group
  typedef struct packed
  {
    logic sample_valid;
    logic [7:0] rssi_sample;
    logic sfd_found;
    logic frame_ongoing;
    logic corr_valid;
    logic [7:0] corr_value;
  } rx_observe_t;

  // Event outputs group, each a one-cycle pulse
  typedef struct packed
  {
    logic energy_scan_done_event;
    logic energy_scan_halted_event;
    logic channel_clear_event;
    logic channel_occupied_event;
    logic assess_halted_event;
    logic transmit_rampup_task;
    logic stop_task;
    logic disable_task;
  } events_t;
endpackage

// *** verif/energy_detect_and_cca_tb.sv ***
// Self-checking bench for the energy detect and channel assessment engine
`timescale 1ns/1ps
module energy_detect_and_cca_tb;
  // Short symbol keeps each window at 32 cycles
  localparam int SYM = 4;
  localparam int WIN = edcca_pkg::WINDOW_SYMBOLS * SYM;
  // Event bits, msb first as the event struct packs them
  localparam logic [7:0] E_DONE = 8'h80;
  localparam logic [7:0] E_SHALT = 8'h40;
  localparam logic [7:0] E_CLR = 8'h20;
  localparam logic [7:0] E_OCC = 8'h10;
  localparam logic [7:0] E_AHALT = 8'h08;
  localparam logic [7:0] E_TX = 8'h04;
  localparam logic [7:0] E_STOP = 8'h02;
  localparam logic [7:0] E_DIS = 8'h01;
  // Level scale used by the standard conversion in software
  localparam int level_scale_constant = 4;

  logic clk = 1'b0; // Bench clock
  logic rst_n = 1'b0; // Held low for ten cycles
  logic [4:0] tk = 5'h00; // Scan begin, scan halt, assess begin, assess halt, rx ready
  logic [7:0] iters = 8'h00; // Scan iteration count
  edcca_pkg::assess_control_t ctl = '0; // Assessment settings
  logic [3:0] sc = 4'hf; // Shortcuts: clear-transmit_rampup_task, clear-stop, busy-disable, ready-assess
  edcca_pkg::rx_observe_t rx = '0; // Receiver observations
  logic [7:0] level; // Scan result
  logic scan_act; // Scan busy flag
  logic assess_act; // Assessment busy flag
  edcca_pkg::events_t ev_o; // Event pulses
  logic [1:0] act2; // Scan and assess flags, two cycles into a job
  int n_fail = 0;
  int n_tests = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  // Unit under test with a shortened symbol
  edcca_unit #(.SYM_CYCLES(SYM)) dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .energy_scan_begin_task(tk[0]),
    .energy_scan_halt_task(tk[1]),
    .assess_begin_task(tk[2]),
    .assess_halt_task(tk[3]),
    .receive_ready_event(tk[4]),
    .energy_scan_iterations(iters),
    .assess_control(ctl),
    .short_clear_transmit_rampup_task(sc[3]),
    .short_clear_stop(sc[2]),
    .short_busy_disable(sc[1]),
    .short_ready_assess(sc[0]),
    .rx_obs(rx),
    .energy_level_result(level),
    .scan_active(scan_act),
    .assess_active(assess_act),
    .events(ev_o)
  );

  // Verdict and end of run, shared with the watchdog
  task automatic close_out();
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One comparison, counted, and reported at once if it fails
  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok)
    begin
      n_fail++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  // Verdict landed one cycle after an eight-symbol window
  function automatic bit inwin(input int n);
    return n >= WIN && n <= WIN + 2;
  endfunction

  // Software view of a level on the 0 to 255 scale, saturating at the top
  function automatic logic [7:0] std_level(input logic [7:0] v);
    return (int'(v) * level_scale_constant > 32'h000000ff) ? 8'hff : 8'(int'(v) * level_scale_constant);
  endfunction

  // Assessment settings, applied on an edge
  task automatic cfg(input logic [1:0] m, input logic [7:0] thr, input logic [7:0] lim,
                     input logic ong);
    @(posedge clk);
    ctl <= {m, thr, lim, 8'h80};
    rx.frame_ongoing <= ong;
  endtask

  // Pulse task b, then feed the receiver until an event shows.
  // Valid samples alternate lvl and lvl+0x10 over an even-length span, so average is lvl+8.
  task automatic run(input int b, input int h, input int halt_at, input logic [7:0] lvl,
                     input int vlo, input int vhi, input int sfd_at, input int npk,
                     output logic [7:0] ev, output int n);
    int k;
    ev = 8'h00;
    k = 0;
    act2 = 2'b00;
    @(posedge clk);
    tk[b] <= 1'b1;
    @(posedge clk);
    tk[b] <= 1'b0;
    while (ev === 8'h00 && k < 400)
    begin
      @(posedge clk);
      k++;
      rx.sample_valid <= (k >= vlo && k <= vhi);
      rx.rssi_sample <= (k >= vlo && k <= vhi) ? lvl + (k[0] ? 8'h10 : 8'h00) : ~lvl;
      rx.sfd_found <= (k == sfd_at);
      rx.corr_valid <= 1'b1; // Receiver stays live through every job
      rx.corr_value <= (k >= 2 && k < 2 + npk) ? 8'h90 : 8'h10;
      tk[h] <= (k == halt_at);
      #1;
      ev = ev_o;
      if (k == 2)
        act2 = {scan_act, assess_act};
    end
    n = k;
    @(posedge clk);
    rx.sample_valid <= 1'b0;
    rx.sfd_found <= 1'b0;
    rx.corr_valid <= 1'b0;
    tk <= 5'h00;
  endtask

  // Single scan averages, then one done pulse
  task automatic t_scan_single();
    logic [7:0] ev;
    int n;
    run(0, 1, -1, 8'h38, 4, 27, -1, 0, ev, n);
    chk(ev === E_DONE, "scan done event");
    chk(inwin(n), "scan window length");
    chk(level === 8'h40, "scan average");
    chk(act2 === 2'b10, "scan active flag");
    chk(std_level(level) === 8'hff, "standard scale");
  endtask

  // Three windows, energy only in the second, keep the maximum
  task automatic t_scan_multi();
    logic [7:0] ev;
    int n;
    int extra;
    extra = 0;
    @(posedge clk);
    iters <= 8'h03;
    run(0, 1, -1, 8'h48, 40, 55, -1, 0, ev, n);
    chk(ev === E_DONE && n >= 3 * WIN && n <= 3 * WIN + 6, "multi scan done");
    chk(level === 8'h50, "multi scan maximum");
    repeat (2 * WIN)
    begin
      @(posedge clk);
      #1;
      if (ev_o !== 8'h00)
        extra++;
    end
    chk(extra == 0, "second done event");
    @(posedge clk);
    iters <= 8'h00;
  endtask

  // Scan halted in mid-window
  task automatic t_scan_halt();
    logic [7:0] ev;
    int n;
    run(0, 1, 5, 8'h20, 1, 400, -1, 0, ev, n);
    chk(ev === E_SHALT && n >= 6 && n <= 7, "scan halted event");
  endtask

  // Energy mode around the threshold, shortcuts on and partly off
  task automatic t_cca_energy();
    logic [7:0] ev;
    int n;
    cfg(2'h0, 8'h40, 8'h00, 1'b0);
    run(2, 3, -1, 8'h38, 4, 27, -1, 0, ev, n);
    chk(ev === (E_OCC | E_DIS) && inwin(n), "busy at threshold");
    chk(act2 === 2'b01, "assess active flag");
    run(2, 3, -1, 8'h37, 4, 27, -1, 0, ev, n);
    chk(ev === (E_CLR | E_TX | E_STOP) && inwin(n), "clear below");
    sc <= 4'h4;
    run(2, 3, -1, 8'h37, 4, 27, -1, 0, ev, n);
    chk(ev === (E_CLR | E_STOP), "clear stop only");
    run(2, 3, -1, 8'h38, 4, 27, -1, 0, ev, n);
    chk(ev === E_OCC, "busy no disable");
    sc <= 4'hf;
  endtask

  // Carrier mode: ongoing frame, delimiter, correlator peaks
  task automatic t_cca_carrier();
    logic [7:0] ev;
    int n;
    cfg(2'h1, 8'h40, 8'h00, 1'b1);
    run(2, 3, -1, 8'h10, 1, 0, -1, 0, ev, n);
    chk(ev === (E_OCC | E_DIS) && inwin(n), "ongoing frame busy");
    cfg(2'h1, 8'h40, 8'h00, 1'b0);
    run(2, 3, -1, 8'h10, 1, 0, 5, 0, ev, n);
    chk(ev === (E_OCC | E_DIS) && n < WIN, "delimiter busy early");
    run(2, 3, -1, 8'h60, 4, 27, -1, 0, ev, n);
    chk(ev === (E_CLR | E_TX | E_STOP) && inwin(n), "no carrier clear");
    cfg(2'h1, 8'h40, 8'h02, 1'b0);
    run(2, 3, -1, 8'h10, 1, 0, -1, 2, ev, n);
    chk(ev === (E_OCC | E_DIS) && n < WIN, "peak limit busy");
    run(2, 3, -1, 8'h10, 1, 0, -1, 1, ev, n);
    chk(ev === (E_CLR | E_TX | E_STOP) && inwin(n), "one peak clear");
  endtask

  // Combined modes: AND and OR of energy and carrier
  task automatic t_cca_combined();
    logic [7:0] ev;
    int n;
    cfg(2'h2, 8'h40, 8'h00, 1'b0);
    run(2, 3, -1, 8'h48, 4, 27, -1, 0, ev, n);
    chk(ev === (E_CLR | E_TX | E_STOP), "and, energy only");
    run(2, 3, -1, 8'h48, 4, 27, 5, 0, ev, n);
    chk(ev === (E_OCC | E_DIS), "and, both");
    cfg(2'h3, 8'h40, 8'h00, 1'b0);
    run(2, 3, -1, 8'h10, 4, 27, -1, 0, ev, n);
    chk(ev === (E_CLR | E_TX | E_STOP), "or, neither");
    run(2, 3, -1, 8'h48, 4, 27, -1, 0, ev, n);
    chk(ev === (E_OCC | E_DIS), "or, energy only");
    run(2, 3, -1, 8'h10, 4, 27, 5, 0, ev, n);
    chk(ev === (E_OCC | E_DIS) && n < WIN, "or, delimiter early");
  endtask

  // Halt, then ready shortcut on and off
  task automatic t_cca_halt_ready();
    logic [7:0] ev;
    int n;
    cfg(2'h0, 8'h40, 8'h00, 1'b0);
    run(2, 3, 6, 8'h48, 1, 400, -1, 0, ev, n);
    chk(ev === E_AHALT && n >= 7 && n <= 8, "assess halted event");
    run(4, 3, -1, 8'h10, 4, 27, -1, 0, ev, n);
    chk(ev === (E_CLR | E_TX | E_STOP) && inwin(n), "ready starts assess");
    sc <= 4'he;
    run(4, 3, -1, 8'h10, 4, 27, -1, 0, ev, n);
    chk(ev === 8'h00 && assess_act === 1'b0, "ready shortcut off");
    sc <= 4'hf;
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_scan_single();
    t_scan_multi();
    t_scan_halt();
    t_cca_energy();
    t_cca_carrier();
    t_cca_combined();
    t_cca_halt_ready();
    close_out();
  end

  // Watchdog, well past the expected run of roughly a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    chk(1'b0, "watchdog expired");
    close_out();
  end
endmodule
